// *** hw/pnm_pin_mux.sv ***
/*
 * Pin multiplexer for four nine-port pins and eight auxiliary-port pins.
 * Assumes pad cells outside: each auxiliary pad takes out, an active-low output
 * enable, a pull-up request and an input-buffer enable, each nine-port pad out,
 * an active-low output enable and a segment enable; each pad returns its
 * synchronised-here raw level. Peripheral and clock signals come from the
 * same clock domain as clk_i or are treated as levels sampled here.
 */
//
// Summary of operation
// (R1) Nine-port pin with selects 00 and no segment is plain I/O by direction.
// (R2) Nine pin 0 selects 01 is timer1 ch0; pins 1-3 selects 10 give clocks.
// (R3) Unassigned select with direction 1 drives the pin from ground.
// (R4) Segment enable makes a nine-port pin an LCD segment line.
// (R5) Aux pins 0-3 selects 01 output clocks; selects 11 give peripheral links.
// (R6) Aux pins 0-3 selects 10 output the CPU status flags.
// (R7) Pad-disable bit turns off driver and input, pin becomes analog input.
// (R8) Comparator selecting a pin disables its driver and input buffer.
// (R9) While test mode is active the test module sets test-pin direction.
// (R10) Test mode enters by system control or four-wire debug entry.
// (R11) In test mode selects and pad-disable bits do not touch test pins.
// (R12) Test mode enables pull-ups on mode, clock and data-in test pins.
// (R13) Aux pin 4 with selects 01 is the low-frequency oscillator input.
// (R14) Low-frequency crystal mode uses pins 4 and 5; pin 5 selects ignored.
// (R15) Low-frequency bypass takes an external clock; pin 5 is plain I/O.
// (R16) Pin 5 with any select set has no input and drives low on output.
// (R17) Aux pin 6 with selects 01 is the high-frequency oscillator input.
// (R18) High-frequency crystal mode uses pins 6 and 7; pin 7 selects ignored.
// (R19) High-frequency bypass takes an external clock; pin 7 is plain I/O.
// (R20) Pin 7 with any select set has no input and drives low on output.
// (R21) After reset aux pins 0-3 are plain I/O with selects and pad-disable 0.
`timescale 1ns/1ps

module pnm_pin_mux
	import pnm_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	// Nine-port controls and data.
	input  wire logic [PNM_NINE_W-1:0] nine_port_direction_bit_i,
	input  wire logic [PNM_NINE_W-1:0] nine_port_select_high_i,
	input  wire logic [PNM_NINE_W-1:0] nine_port_select_low_i,
	input  wire logic [PNM_NINE_W-1:0] lcd_segment_enable_i,
	input  wire logic [PNM_NINE_W-1:0] nine_port_out_i,
	input  wire logic [PNM_NINE_W-1:0] nine_pad_in_i,
	output logic      [PNM_NINE_W-1:0] nine_pad_out_o,
	output logic      [PNM_NINE_W-1:0] nine_pad_oe_n_o,
	output logic      [PNM_NINE_W-1:0] nine_pad_lcd_o,
	output logic      [PNM_NINE_W-1:0] nine_port_in_o,
	// Auxiliary-port controls and data.
	input  wire logic [PNM_AUX_W-1:0]  aux_port_direction_bit_i,
	input  wire logic [PNM_AUX_W-1:0]  aux_port_select_high_i,
	input  wire logic [PNM_AUX_W-1:0]  aux_port_select_low_i,
	input  wire logic [PNM_AUX_W-1:0]  aux_port_pull_enable_i,
	input  wire logic [PNM_AUX_W-1:0]  aux_port_out_i,
	input  wire logic [PNM_AUX_W-1:0]  aux_pad_in_i,
	output logic      [PNM_AUX_W-1:0]  aux_pad_out_o,
	output logic      [PNM_AUX_W-1:0]  aux_pad_oe_n_o,
	output logic      [PNM_AUX_W-1:0]  aux_pad_pull_o,
	output logic      [PNM_AUX_W-1:0]  aux_pad_in_en_o,
	output logic      [PNM_AUX_W-1:0]  aux_port_in_o,
	// Comparator controls.
	input  wire logic [PNM_JTAG_W-1:0] comparator_pad_disable_i,
	input  wire logic [3:0]            comparator_input_select_i,
	input  wire logic                  comparator_select_valid_i,
	output logic      [PNM_JTAG_W-1:0] comparator_analog_input_o,
	// Test-port controls.
	input  wire logic                  system_control_unit_jtag_i,
	input  wire logic                  debug_four_wire_entry_i,
	input  wire logic [PNM_JTAG_W-1:0] jtag_dir_i,
	input  wire logic [PNM_JTAG_W-1:0] jtag_out_i,
	output logic      [PNM_JTAG_W-1:0] jtag_in_o,
	output logic                       jtag_active_o,
	// Oscillator controls.
	input  wire logic                  low_freq_bypass_i,
	input  wire logic                  high_freq_bypass_i,
	output logic                       low_freq_crystal_en_o,
	output logic                       low_freq_ext_clock_en_o,
	output logic                       low_freq_crystal_in_o,
	output logic                       high_freq_crystal_en_o,
	output logic                       high_freq_ext_clock_en_o,
	output logic                       high_freq_crystal_in_o,
	// Peripheral and clock sources.
	input  wire logic                  timer1_ch0_output_i,
	input  wire logic                  aux_clock_i,
	input  wire logic                  sub_main_clock_i,
	input  wire logic                  main_clock_i,
	input  wire logic                  rtc_clock_output_i,
	input  wire logic                  clock_gen1_off_flag_i,
	input  wire logic                  clock_gen0_off_flag_i,
	input  wire logic                  oscillator_shutdown_flag_i,
	input  wire logic                  cpu_halt_flag_i,
	input  wire logic                  timer_b_ch6_output_i,
	// Peripheral inputs.
	output logic                       timer1_ch0_capture_b_o,
	output logic                       dma_external_trigger0_o,
	output logic                       timer4_external_clock_o,
	output logic                       timer_b_hiz_control_o,
	output logic                       timer_b_ch6_capture_a_o
);

	// Pad inputs cross from outside: three stages, second and third agree.
	logic [PNM_NINE_W-1:0] n_s1_q, n_s2_q, n_s3_q, n_st_q, n_st_d;
	logic [PNM_AUX_W-1:0]  a_s1_q, a_s2_q, a_s3_q, a_st_q, a_st_d;

	// Combinational pad controls, registered before leaving the block.
	logic [PNM_NINE_W-1:0] n_out_d, n_oe_n_d, n_lcd_d;
	logic [PNM_NINE_W-1:0] n_out_q, n_oe_n_q, n_lcd_q;
	logic [PNM_AUX_W-1:0]  a_out_d, a_oe_n_d, a_pull_d, a_ien_d;
	logic [PNM_AUX_W-1:0]  a_out_q, a_oe_n_q, a_pull_q, a_ien_q;
	logic [PNM_JTAG_W-1:0] ana_d, ana_q;
	logic                  jtag_d, jtag_q;

	// Two-bit select code of pin i.
	function automatic logic [1:0] sel_of(input logic hi, input logic lo);
		sel_of = {hi, lo};
	endfunction

	// Stable level: follow stage three only once stages two and three agree.
	always_comb
	begin
		n_st_d = n_st_q;
		a_st_d = a_st_q;
		for (int i = 0; i < PNM_NINE_W; i++)
			if (n_s2_q[i] == n_s3_q[i])
				n_st_d[i] = n_s3_q[i];
		for (int i = 0; i < PNM_AUX_W; i++)
			if (a_s2_q[i] == a_s3_q[i])
				a_st_d[i] = a_s3_q[i];
	end

	// Synchroniser stages and the filtered level.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			n_s1_q <= '0;
			n_s2_q <= '0;
			n_s3_q <= '0;
			n_st_q <= '0;
			a_s1_q <= '0;
			a_s2_q <= '0;
			a_s3_q <= '0;
			a_st_q <= '0;
		end
		else
		begin
			n_s1_q <= nine_pad_in_i;
			n_s2_q <= n_s1_q;
			n_s3_q <= n_s2_q;
			n_st_q <= n_st_d;
			a_s1_q <= aux_pad_in_i;
			a_s2_q <= a_s1_q;
			a_s3_q <= a_s2_q;
			a_st_q <= a_st_d;
		end
	end

	// Nine-port function selection; segment enable beats everything.
	always_comb
	begin
		logic [1:0] s;
		logic       d;
		s = '0;
		d = 1'b0;
		n_out_d  = '0;
		n_oe_n_d = '1;
		n_lcd_d  = '0;
		for (int i = 0; i < PNM_NINE_W; i++)
		begin
			s = sel_of(nine_port_select_high_i[i], nine_port_select_low_i[i]);
			d = nine_port_direction_bit_i[i];
			if (lcd_segment_enable_i[i])
				n_lcd_d[i] = 1'b1; // R4
			else
			begin
				n_oe_n_d[i] = ~d; // R1
				case (s)
					PNM_SEL_GPIO: n_out_d[i] = nine_port_out_i[i]; // R1
					PNM_SEL_LOW:
						n_out_d[i] = (i == 0) ? timer1_ch0_output_i
							: 1'b0; // R2 R3
					PNM_SEL_HIGH:
						case (i)
							1: n_out_d[i] = sub_main_clock_i; // R2
							2: n_out_d[i] = main_clock_i;
							3: n_out_d[i] = aux_clock_i;
							default: n_out_d[i] = 1'b0; // R3
						endcase
					default: n_out_d[i] = 1'b0; // R3
				endcase
			end
		end
	end

	// Auxiliary-port function selection, test mode and oscillators.
	always_comb
	begin
		logic [1:0] s;
		logic       d;
		logic       jt;
		logic       lf_osc, hf_osc;
		logic [PNM_JTAG_W-1:0] cmp_sel;
		s = '0;
		d = 1'b0;
		jt = system_control_unit_jtag_i | debug_four_wire_entry_i; // R10
		jtag_d = jt;
		lf_osc = sel_of(aux_port_select_high_i[PNM_LF_IN],
			aux_port_select_low_i[PNM_LF_IN]) == PNM_SEL_LOW; // R13
		hf_osc = sel_of(aux_port_select_high_i[PNM_HF_IN],
			aux_port_select_low_i[PNM_HF_IN]) == PNM_SEL_LOW; // R17
		cmp_sel = '0;
		for (int i = 0; i < PNM_JTAG_W; i++)
			cmp_sel[i] = comparator_select_valid_i &&
				(comparator_input_select_i == PNM_CMP_FIRST + 4'(i)); // R8
		a_out_d  = '0;
		a_oe_n_d = '1;
		a_ien_d  = '1;
		a_pull_d = aux_port_pull_enable_i;
		ana_d    = '0;
		for (int i = 0; i < PNM_AUX_W; i++)
		begin
			s = sel_of(aux_port_select_high_i[i], aux_port_select_low_i[i]);
			d = aux_port_direction_bit_i[i];
			if (i < PNM_JTAG_W && jt)
			begin
				// Test module owns direction and data.
				a_oe_n_d[i] = ~jtag_dir_i[i]; // R9 R11
				a_out_d[i]  = jtag_out_i[i];
				if (i != PNM_TDO)
					a_pull_d[i] = 1'b1; // R12
			end
			else if (i < PNM_JTAG_W &&
				(comparator_pad_disable_i[i] || cmp_sel[i]))
			begin
				a_ien_d[i] = 1'b0; // R7 R8
				ana_d[i]   = 1'b1; // R7
			end
			else if (i < PNM_JTAG_W)
			begin
				a_oe_n_d[i] = ~d;
				case (s)
					PNM_SEL_GPIO: a_out_d[i] = aux_port_out_i[i]; // R21
					PNM_SEL_LOW:
						case (i)
							0: a_out_d[i] = aux_clock_i; // R5
							1: a_out_d[i] = sub_main_clock_i;
							2: a_out_d[i] = main_clock_i;
							default: a_out_d[i] = rtc_clock_output_i;
						endcase
					PNM_SEL_HIGH:
						case (i)
							0: a_out_d[i] = clock_gen1_off_flag_i; // R6
							1: a_out_d[i] = clock_gen0_off_flag_i;
							2: a_out_d[i] = oscillator_shutdown_flag_i;
							default: a_out_d[i] = cpu_halt_flag_i;
						endcase
					default:
						a_out_d[i] = (i == PNM_TCK) ? timer_b_ch6_output_i
							: 1'b0; // R5 R3
				endcase
			end
			else if ((i == PNM_LF_IN && lf_osc) || (i == PNM_HF_IN && hf_osc))
			begin
				// Oscillator input: no digital driver or buffer.
				a_ien_d[i] = 1'b0; // R13 R17
			end
			else if ((i == PNM_LF_OUT && lf_osc && !low_freq_bypass_i) ||
				(i == PNM_HF_OUT && hf_osc && !high_freq_bypass_i))
			begin
				a_ien_d[i] = 1'b0; // R14 R18
			end
			else if ((i == PNM_LF_OUT || i == PNM_HF_OUT) && s != PNM_SEL_GPIO
				&& !((i == PNM_LF_OUT && lf_osc) ||
				(i == PNM_HF_OUT && hf_osc)))
			begin
				a_ien_d[i]  = 1'b0; // R16 R20
				a_oe_n_d[i] = ~d;
				a_out_d[i]  = 1'b0;
			end
			else if ((i == PNM_LF_IN || i == PNM_HF_IN) && s != PNM_SEL_GPIO)
			begin
				a_oe_n_d[i] = ~d;
				a_out_d[i]  = 1'b0; // R3
			end
			else
			begin
				a_oe_n_d[i] = ~d; // R15 R19
				a_out_d[i]  = aux_port_out_i[i];
			end
		end
	end

	// Registered pad controls; defaults leave every pad as an input.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			n_out_q  <= PNM_RST_OUT[PNM_NINE_W-1:0];
			n_oe_n_q <= PNM_RST_OE[PNM_NINE_W-1:0];
			n_lcd_q  <= '0;
			a_out_q  <= PNM_RST_OUT;
			a_oe_n_q <= PNM_RST_OE;
			a_pull_q <= '0;
			a_ien_q  <= '1;
			ana_q    <= '0;
			jtag_q   <= 1'b0;
		end
		else
		begin
			n_out_q  <= n_out_d;
			n_oe_n_q <= n_oe_n_d;
			n_lcd_q  <= n_lcd_d;
			a_out_q  <= a_out_d;
			a_oe_n_q <= a_oe_n_d;
			a_pull_q <= a_pull_d;
			a_ien_q  <= a_ien_d;
			ana_q    <= ana_d;
			jtag_q   <= jtag_d;
		end
	end

	// Pad-facing outputs come straight from flip-flops.
	assign nine_pad_out_o            = n_out_q;
	assign nine_pad_oe_n_o           = n_oe_n_q;
	assign nine_pad_lcd_o            = n_lcd_q;
	assign aux_pad_out_o             = a_out_q;
	assign aux_pad_oe_n_o            = a_oe_n_q;
	assign aux_pad_pull_o            = a_pull_q;
	assign aux_pad_in_en_o           = a_ien_q;
	assign comparator_analog_input_o = ana_q;
	assign jtag_active_o             = jtag_q;

	// Input routing uses the filtered level, gated by the buffer enable (aux), segment enable (nine) or test mode (test pins).
	assign nine_port_in_o = n_st_q & ~n_lcd_q;
	assign aux_port_in_o  = a_st_q & a_ien_q;
	assign jtag_in_o      = jtag_q ? a_st_q[PNM_JTAG_W-1:0] : '0;

	// Peripheral inputs are only live when their select picks them.
	assign timer1_ch0_capture_b_o  = a_n_sel(0, PNM_SEL_LOW)
		& n_st_q[0]; // R2
	assign dma_external_trigger0_o = a_sel(PNM_TDO) & aux_port_in_o[PNM_TDO];
	assign timer4_external_clock_o = a_sel(PNM_TDI) & aux_port_in_o[PNM_TDI];
	assign timer_b_hiz_control_o   = a_sel(PNM_TMS) & aux_port_in_o[PNM_TMS];
	assign timer_b_ch6_capture_a_o = a_sel(PNM_TCK) & aux_port_in_o[PNM_TCK];

	// Oscillator status toward the clock system.
	assign low_freq_crystal_in_o    = aux_pad_in_i[PNM_LF_IN];
	assign high_freq_crystal_in_o   = aux_pad_in_i[PNM_HF_IN];
	assign low_freq_crystal_en_o    = ~a_ien_q[PNM_LF_OUT]
		& ~low_freq_bypass_i & ~a_ien_q[PNM_LF_IN]; // R14
	assign low_freq_ext_clock_en_o  = ~a_ien_q[PNM_LF_IN]
		& low_freq_bypass_i; // R15
	assign high_freq_crystal_en_o   = ~a_ien_q[PNM_HF_OUT]
		& ~high_freq_bypass_i & ~a_ien_q[PNM_HF_IN]; // R18
	assign high_freq_ext_clock_en_o = ~a_ien_q[PNM_HF_IN]
		& high_freq_bypass_i; // R19

	// Auxiliary pin i selected 11, input direction, not in test mode.
	function automatic logic a_sel(input int i);
		a_sel = !jtag_q && aux_port_select_high_i[i]
			&& aux_port_select_low_i[i] && !aux_port_direction_bit_i[i];
	endfunction
	// Nine-port pin i selected as given, input direction, no segment.
	function automatic logic a_n_sel(input int i, input logic [1:0] s);
		a_n_sel = !lcd_segment_enable_i[i] && !nine_port_direction_bit_i[i]
			&& sel_of(nine_port_select_high_i[i],
			nine_port_select_low_i[i]) == s;
	endfunction
endmodule

// *** hw/pnm_pkg.sv ***
/*
 * Constants for the nine-port and auxiliary-port pin multiplexer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pnm_pkg;

	// Select codes, written as {select_high, select_low}.
	localparam logic [1:0] PNM_SEL_GPIO = 2'h0;
	localparam logic [1:0] PNM_SEL_LOW  = 2'h1;
	localparam logic [1:0] PNM_SEL_HIGH = 2'h2;
	localparam logic [1:0] PNM_SEL_BOTH = 2'h3;

	// Port widths and pin positions.
	localparam int PNM_NINE_W = 4;
	localparam int PNM_AUX_W  = 8;
	localparam int PNM_JTAG_W = 4;
	localparam int PNM_LF_IN  = 4;
	localparam int PNM_LF_OUT = 5;
	localparam int PNM_HF_IN  = 6;
	localparam int PNM_HF_OUT = 7;

	// Test-pin positions on the auxiliary port.
	localparam int PNM_TDO = 0;
	localparam int PNM_TDI = 1;
	localparam int PNM_TMS = 2;
	localparam int PNM_TCK = 3;

	// Reset values of the registered pad controls.
	localparam logic [7:0] PNM_RST_OUT = 8'h00;
	localparam logic [7:0] PNM_RST_OE  = 8'hff;

	// Comparator input-select codes that reach pins 0 to 3.
	localparam logic [3:0] PNM_CMP_FIRST = 4'ha;

endpackage

// *** tb/pnm_pad_model.sv ***
/*
 * Board-side model of a row of pads.
 * Assumes the mux drives active-low output enables.
 */
`timescale 1ns/1ps
module pnm_pad_model
#(
	parameter int W = 8
)
(
	input  wire logic [W-1:0] out_i,
	input  wire logic [W-1:0] oe_n_i,
	input  wire logic [W-1:0] pull_i,
	input  wire logic [W-1:0] ext_i,
	output logic      [W-1:0] pad_o
);
	// A released pad goes to its pull-up, else to the outside level.
	always_comb
	begin
		for (int i = 0; i < W; i++)
			pad_o[i] = !oe_n_i[i] ? out_i[i] : (pull_i[i] ? 1'b1 : ext_i[i]);
	end
endmodule

// *** tb/pnm_pin_mux_asserts.sv ***
/*
 * Concurrent checks on the pin multiplexer ports.
 * Assumes pad controls settle one clock after their causes.
 */
`timescale 1ns/1ps
module pnm_pin_mux_asserts
(
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic [3:0] nine_port_direction_bit_i,
	input wire logic [3:0] nine_port_select_high_i,
	input wire logic [3:0] nine_port_select_low_i,
	input wire logic [3:0] lcd_segment_enable_i,
	input wire logic [3:0] nine_pad_out_o,
	input wire logic [3:0] nine_pad_oe_n_o,
	input wire logic [3:0] nine_pad_lcd_o,
	input wire logic       sub_main_clock_i,
	input wire logic [7:0] aux_port_direction_bit_i,
	input wire logic [7:0] aux_port_select_high_i,
	input wire logic [7:0] aux_port_select_low_i,
	input wire logic [7:0] aux_pad_out_o,
	input wire logic [7:0] aux_pad_oe_n_o,
	input wire logic [7:0] aux_pad_pull_o,
	input wire logic [7:0] aux_pad_in_en_o,
	input wire logic [3:0] comparator_pad_disable_i,
	input wire logic [3:0] comparator_input_select_i,
	input wire logic       comparator_select_valid_i,
	input wire logic [3:0] comparator_analog_input_o,
	input wire logic       system_control_unit_jtag_i,
	input wire logic       debug_four_wire_entry_i,
	input wire logic [3:0] jtag_dir_i,
	input wire logic       jtag_active_o,
	input wire logic       low_freq_bypass_i
);
	// Short aliases keep the properties readable.
	wire [3:0] nh = nine_port_select_high_i;
	wire [3:0] nl = nine_port_select_low_i;
	wire [3:0] nd = nine_port_direction_bit_i;
	wire [3:0] nz = lcd_segment_enable_i;
	wire [7:0] ah = aux_port_select_high_i;
	wire [7:0] al = aux_port_select_low_i;
	wire       jt = system_control_unit_jtag_i | debug_four_wire_entry_i;

	// All checks share one clock and stay quiet during reset.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_clk;
		nh[1] && !nl[1] && nd[1] && !nz[1]
		|=> !nine_pad_oe_n_o[1] && nine_pad_out_o[1] == $past(sub_main_clock_i);
	endproperty
	a_clk: assert property (p_clk)
		else $error("nine pin 1 lacks the sub-main clock");

	property p_gnd;
		nh[0] && !nl[0] && nd[0] && !nz[0]
		|=> !nine_pad_oe_n_o[0] && !nine_pad_out_o[0];
	endproperty
	a_gnd: assert property (p_gnd)
		else $error("unassigned nine pin 0 not grounded");

	property p_lcd;
		|nz |=> nine_pad_lcd_o == $past(nz);
	endproperty
	a_lcd: assert property (p_lcd)
		else $error("segment enable not followed");

	property p_pd;
		comparator_pad_disable_i[1] && !jt |=> comparator_analog_input_o[1]
			&& aux_pad_oe_n_o[1] && !aux_pad_in_en_o[1];
	endproperty
	a_pd: assert property (p_pd)
		else $error("pad disable ignored on aux pin 1");

	property p_cmp;
		comparator_select_valid_i && comparator_input_select_i == 4'hc && !jt
		|=> comparator_analog_input_o[2] && aux_pad_oe_n_o[2]
			&& !aux_pad_in_en_o[2];
	endproperty
	a_cmp: assert property (p_cmp)
		else $error("comparator select ignored on aux pin 2");

	property p_jdir;
		jt |=> jtag_active_o && aux_pad_oe_n_o[3:0] == ~$past(jtag_dir_i);
	endproperty
	a_jdir: assert property (p_jdir)
		else $error("test pin direction not from test module");

	property p_pull;
		jt ##1 jt |-> &aux_pad_pull_o[3:1];
	endproperty
	a_pull: assert property (p_pull)
		else $error("test pin pull-ups missing");

	property p_lfx;
		!ah[4] && al[4] && !low_freq_bypass_i
		|=> &aux_pad_oe_n_o[5:4] && aux_pad_in_en_o[5:4] == 2'h0;
	endproperty
	a_lfx: assert property (p_lfx)
		else $error("crystal pins still digital");

	property p_gp5;
		(ah[5] || al[5]) && aux_port_direction_bit_i[5] && !(!ah[4] && al[4])
		|=> !aux_pad_oe_n_o[5] && !aux_pad_out_o[5] && !aux_pad_in_en_o[5];
	endproperty
	a_gp5: assert property (p_gp5)
		else $error("aux pin 5 not pulled low");

	c_jtag: cover property (jtag_active_o);
	c_analog: cover property (comparator_analog_input_o != 4'h0);
	c_xtal: cover property (!ah[4] && al[4] ##1 &aux_pad_oe_n_o[5:4]);
endmodule

bind pnm_pin_mux pnm_pin_mux_asserts u_asserts (.*);

// *** tb/pnm_pin_mux_tb_top.sv ***
/*
 * Self-checking bench for the pin multiplexer.
 * Assumes pads settle one clock after controls, inputs within four.
 */
`timescale 1ns/1ps
module pnm_pin_mux_tb_top;
	logic clk_i = 1'b0, rst_n_i = 1'b0, comparator_select_valid_i = 1'b0;
	logic system_control_unit_jtag_i = 1'b0, debug_four_wire_entry_i = 1'b0;
	logic low_freq_bypass_i = 1'b0, high_freq_bypass_i = 1'b0;
	logic timer1_ch0_output_i = 1'b0, timer_b_ch6_output_i = 1'b0;
	logic [3:0] nine_port_direction_bit_i = 4'h0, nine_port_select_high_i = 4'h0;
	logic [3:0] nine_port_select_low_i = 4'h0, lcd_segment_enable_i = 4'h0;
	logic [3:0] nine_port_out_i = 4'h0, comparator_pad_disable_i = 4'h0;
	logic [3:0] comparator_input_select_i = 4'h0, jtag_dir_i = 4'h0;
	logic [3:0] jtag_out_i = 4'h0, clks = 4'h0, flags = 4'h0, nine_ext = 4'h0;
	logic [7:0] aux_port_direction_bit_i = 8'h00, aux_port_out_i = 8'h00;
	logic [7:0] aux_port_select_high_i = 8'h00, aux_port_select_low_i = 8'h00;
	logic [7:0] aux_port_pull_enable_i = 8'h00, aux_ext = 8'h00;
	logic aux_clock_i, sub_main_clock_i, main_clock_i, rtc_clock_output_i;
	logic clock_gen1_off_flag_i, clock_gen0_off_flag_i;
	logic oscillator_shutdown_flag_i, cpu_halt_flag_i;
	logic [3:0] nine_pad_in_i, nine_pad_out_o, nine_pad_oe_n_o, nine_pad_lcd_o;
	logic [3:0] nine_port_in_o, comparator_analog_input_o, jtag_in_o;
	logic [7:0] aux_pad_in_i, aux_pad_out_o, aux_pad_oe_n_o, aux_pad_pull_o;
	logic [7:0] aux_pad_in_en_o, aux_port_in_o;
	logic jtag_active_o, low_freq_crystal_en_o, low_freq_ext_clock_en_o;
	logic low_freq_crystal_in_o, high_freq_crystal_en_o, high_freq_crystal_in_o;
	logic high_freq_ext_clock_en_o, timer1_ch0_capture_b_o;
	logic dma_external_trigger0_o, timer4_external_clock_o;
	logic timer_b_hiz_control_o, timer_b_ch6_capture_a_o;
	logic [3:0] d, h, l, z, o, el, eo, ed;
	logic [4:0] s;
	int err_count = 0;
	int tests_run = 0;
	// Rows: dir, sel high, sel low, segment, out, sources, then lcd, oe_n, out.
	logic [36:0] rows [7] = '{
		{4'h5, 4'h0, 4'h0, 4'h0, 4'hf, 5'h00, 4'h0, 4'ha, 4'h5},
		{4'hf, 4'he, 4'h1, 4'h0, 4'h0, 5'h13, 4'h0, 4'h0, 4'hb},
		{4'hf, 4'he, 4'h1, 4'h0, 4'h0, 5'h04, 4'h0, 4'h0, 4'h4},
		{4'hf, 4'h1, 4'he, 4'h0, 4'hf, 5'h1f, 4'h0, 4'h0, 4'h0},
		{4'h0, 4'hf, 4'hf, 4'h0, 4'hf, 5'h00, 4'h0, 4'hf, 4'h0},
		{4'hf, 4'h0, 4'h0, 4'h9, 4'hf, 5'h00, 4'h9, 4'h0, 4'h6},
		{4'h0, 4'h5, 4'ha, 4'hf, 4'h0, 5'h00, 4'hf, 4'h0, 4'h0}};

	// Source levels come from two vectors so the bench can flip them.
	assign {rtc_clock_output_i, main_clock_i, sub_main_clock_i, aux_clock_i} = clks;
	assign {cpu_halt_flag_i, oscillator_shutdown_flag_i, clock_gen0_off_flag_i,
		clock_gen1_off_flag_i} = flags;

	always #5 clk_i = ~clk_i;

	pnm_pin_mux dut (.*);

	pnm_pad_model #(.W(8)) u_aux (.out_i(aux_pad_out_o), .oe_n_i(aux_pad_oe_n_o),
		.pull_i(aux_pad_pull_o), .ext_i(aux_ext), .pad_o(aux_pad_in_i));
	pnm_pad_model #(.W(4)) u_nine (.out_i(nine_pad_out_o),
		.oe_n_i(nine_pad_oe_n_o), .pull_i(4'h0), .ext_i(nine_ext),
		.pad_o(nine_pad_in_i));

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic setaux(input logic [7:0] dd, input logic [7:0] hh,
		input logic [7:0] ll);
		@(posedge clk_i);
		{aux_port_direction_bit_i, aux_port_select_high_i,
			aux_port_select_low_i} <= {dd, hh, ll};
		tick(2);
	endtask

	task automatic summarize();
		if (err_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// A hang is cut short and counted as a mismatch.
	initial
	begin
		repeat (5000) @(posedge clk_i);
		err_count++;
		summarize();
	end

	initial
	begin
		repeat (3) @(posedge clk_i);
		cmp({aux_pad_oe_n_o, comparator_analog_input_o, 3'h0, jtag_active_o},
			16'hff00);
		rst_n_i <= 1'b1;
		tick(2);
		cmp({aux_pad_oe_n_o, aux_pad_pull_o}, 16'hff00);
		foreach (rows[i])
		begin
			{d, h, l, z, o, s, el, eo, ed} = rows[i];
			@(posedge clk_i);
			{nine_port_direction_bit_i, nine_port_select_high_i,
				nine_port_select_low_i, lcd_segment_enable_i, nine_port_out_i,
				timer1_ch0_output_i, clks} <= {d, h, l, z, o, s};
			tick(2);
			cmp({nine_pad_lcd_o, nine_pad_oe_n_o & ~nine_pad_lcd_o, nine_pad_out_o
				& ~nine_pad_oe_n_o & ~nine_pad_lcd_o}, {el, eo, ed});
		end
		@(posedge clk_i);
		{nine_port_direction_bit_i, nine_port_select_high_i,
			nine_port_select_low_i, lcd_segment_enable_i} <= 16'h0010;
		// Both source levels, so a stuck output cannot pass.
		for (int v = 0; v < 2; v++)
		begin
			@(posedge clk_i);
			{clks, flags, timer_b_ch6_output_i, aux_ext, nine_ext} <= {4'h3 ^ {4{v[0]}},
				4'hd ^ {4{v[0]}}, v[0], {8{v[0]}}, {4{v[0]}}};
			setaux(8'h0f, 8'h00, 8'h0f);
			cmp({aux_pad_oe_n_o[3:0], aux_pad_out_o[3:0]}, {4'h0, 4'h3 ^ {4{v[0]}}});
			setaux(8'h0f, 8'h0f, 8'h00);
			cmp({aux_pad_oe_n_o[3:0], aux_pad_out_o[3:0]}, {4'h0, 4'hd ^ {4{v[0]}}});
			setaux(8'h08, 8'h0f, 8'h0f);
			tick(4);
			cmp({aux_pad_out_o[3], aux_pad_oe_n_o[3:0], timer_b_hiz_control_o,
				timer4_external_clock_o, dma_external_trigger0_o,
				timer1_ch0_capture_b_o, nine_port_in_o, low_freq_crystal_in_o,
				high_freq_crystal_in_o}, {v[0], 4'h7, {10{v[0]}}});
			// Pin 3 as an input feeds timer B; pins 0-2 out sit on ground.
			setaux(8'h07, 8'h0f, 8'h0f);
			tick(4);
			cmp({timer_b_ch6_capture_a_o, aux_port_in_o, aux_pad_out_o[2:0],
				aux_pad_oe_n_o[3:0]}, {v[0], {5{v[0]}}, 6'h00, 4'h8});
		end
		setaux(8'h0f, 8'h0f, 8'h00);
		@(posedge clk_i);
		comparator_pad_disable_i <= 4'h2;
		tick(2);
		cmp({comparator_analog_input_o, aux_pad_oe_n_o[3:0], aux_pad_in_en_o[1]},
			{4'h2, 4'h2, 1'b0});
		@(posedge clk_i);
		{comparator_pad_disable_i, comparator_select_valid_i,
			comparator_input_select_i} <= 9'h01c;
		tick(2);
		cmp({comparator_analog_input_o, aux_pad_oe_n_o[3:0], aux_pad_in_en_o[2]},
			{4'h4, 4'h4, 1'b0});
		// Both ways into test mode: the debugger, then system control.
		for (int m = 1; m < 3; m++)
		begin
			@(posedge clk_i);
			{system_control_unit_jtag_i, debug_four_wire_entry_i,
				comparator_pad_disable_i, jtag_dir_i, jtag_out_i, aux_ext} <=
				{2'(m), 4'hf, 4'h1, 4'h1, 8'h00};
			tick(6);
			cmp({jtag_active_o, aux_pad_oe_n_o[3:0], aux_pad_out_o[0],
				aux_pad_pull_o[3:1], comparator_analog_input_o, jtag_in_o},
				{1'b1, 4'he, 1'b1, 3'h7, 4'h0, 4'hf});
		end
		@(posedge clk_i);
		{system_control_unit_jtag_i, debug_four_wire_entry_i,
			comparator_pad_disable_i, comparator_select_valid_i,
			aux_port_out_i} <= {7'h00, 8'hff};
		// Low-frequency pair first, then the high-frequency pair.
		for (int k = 0; k < 2; k++)
		begin
			setaux(8'hff, 8'h20 << (2 * k), 8'h30 << (2 * k));
			cmp({2'(aux_pad_oe_n_o >> (4 + 2 * k)), 2'(aux_pad_in_en_o >> (4 + 2 * k)),
				k ? high_freq_crystal_en_o : low_freq_crystal_en_o},
				{2'h3, 2'h0, 1'b1});
			@(posedge clk_i);
			{high_freq_bypass_i, low_freq_bypass_i} <= 2'(1 << k);
			setaux(8'hff, 8'h00, 8'h10 << (2 * k));
			cmp({2'(aux_pad_oe_n_o >> (4 + 2 * k)), aux_pad_out_o[5 + 2 * k],
				k ? high_freq_ext_clock_en_o : low_freq_ext_clock_en_o},
				{2'h1, 1'b1, 1'b1});
			@(posedge clk_i);
			{high_freq_bypass_i, low_freq_bypass_i} <= 2'h0;
			setaux(8'hff, 8'h20 << (2 * k), 8'h00);
			cmp({aux_pad_oe_n_o[5 + 2 * k], aux_pad_out_o[5 + 2 * k],
				aux_pad_in_en_o[5 + 2 * k]}, 3'h0);
		end
		// A reset in mid-run must release every auxiliary pad at once.
		setaux(8'hff, 8'h00, 8'h00);
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		@(negedge clk_i);
		cmp({aux_pad_oe_n_o, jtag_active_o}, {8'hff, 1'b0});
		@(posedge clk_i);
		rst_n_i <= 1'b1;
		tick(2);
		cmp({aux_pad_oe_n_o, aux_pad_out_o}, 16'h00ff);
		summarize();
	end
endmodule
